/* verilog/refdiv_pkg.sv */
// Package: register map, field positions and shared types for the reference path block
package refdiv_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int RATIO_W = 14;
  // Register indices (byte address equals index on this plain port)
  localparam logic [7:0] REF_DIV_CONTROL_ADDR = 8'h03;
  localparam logic [7:0] GENERAL_OUTPUT_CONTROL_ADDR = 8'h1B;
  localparam logic [7:0] REF_PATH_CONFIG_ADDR = 8'h01;
  localparam logic [7:0] VCO_DIV_CONTROL_ADDR = 8'h20;
  localparam logic [7:0] PATH_STATUS_ADDR = 8'h21;
  // Field positions
  localparam int AUTO_SEL_BIT = 15;
  localparam int MAN_OUT_SEL_BIT = 14;
  localparam int DIV_EN_BIT = 2;
  localparam int SQ_BUF_EN_BIT = 0;
  localparam int SIN_BUF_EN_BIT = 1;
  localparam int SIN_SEL_BIT = 3;
  localparam int SQ_TO_DIG_BIT = 4;
  localparam int DSM_SIN_SEL_BIT = 5;
  localparam int GPO_SEL_LSB = 0;
  localparam int GPO_DATA_LSB = 4;
  localparam int FRAC_MODE_BIT = 0;
  // Reset values
  localparam logic [15:0] REF_DIV_RESET = 16'h8001;
  localparam logic [15:0] REF_PATH_RESET = 16'h0005;
  localparam logic [15:0] GPO_RESET = 16'h0000;
  localparam logic [15:0] VCO_DIV_RESET = 16'h0000;
  localparam logic [13:0] RATIO_ONE = 14'h0001;
  // VCO path limits (fixed divide-by-two included)
  localparam logic [17:0] VCO_INT_MIN = 18'h00040;
  localparam logic [17:0] VCO_INT_MAX = 18'h1FFFE;
  localparam logic [17:0] VCO_FRAC_MIN = 18'h00048;
  localparam logic [17:0] VCO_FRAC_MAX = 18'h1FFF6;
  localparam logic [17:0] VCO_FRAC_SWING = 18'h00004;
  // Output-select codes
  localparam logic [3:0] GPO_DATA = 4'h0;
  localparam logic [3:0] GPO_DIVIDERS = 4'h1;
  localparam logic [3:0] GPO_LOCK = 4'h2;
  localparam logic [3:0] GPO_SLIP = 4'h3;
  localparam logic [3:0] GPO_STROBE = 4'h4;
  localparam logic [3:0] GPO_ACCUM = 4'h6;
  localparam logic [3:0] GPO_AUX = 4'h7;
  localparam logic [3:0] GPO_VCO_LE = 4'h9;
  localparam logic [3:0] GPO_DSM = 4'hA;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Internal waveforms that the output bus may show
  typedef struct packed {
    logic vco_div;
    logic lock_win;
    logic pfd_up;
    logic pfd_dn;
    logic slip_ref;
    logic slip_vco;
    logic pfd_strobe;
    logic frac_strobe;
    logic [2:0] accum_msb;
    logic aux_clk;
    logic ring_osc;
    logic dsm_clk;
    logic [2:0] vco_le;
    logic [2:0] dsm_out;
  } gpo_sources_t;
endpackage : refdiv_pkg

/* verilog/ref_counter.sv */
// Reference divider counter: one output cycle per N input cycles for N of two or more; output keeps its level for N of 0 or 1, low after reset or stop
`timescale 1ns/1ps
`default_nettype none
module ref_counter (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic ref_rise_i,
  input wire logic [13:0] ratio_i,
  output logic div_level_o
);
  logic [13:0] count;
  logic [13:0] half;
  wire last_w = (count >= ratio_i - 14'h0001);
  wire flip_w = (count == half - 14'h0001) || last_w;
  assign half = (ratio_i >> 1) == 14'h0000 ? 14'h0001 : (ratio_i >> 1);

  // Count input rising edges; low for N/2 edges, high for the rest
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      count <= 14'h0000;
      div_level_o <= 1'b0;
    end else if (ce_i) begin
      if (!run_i) begin
        count <= 14'h0000;
        div_level_o <= 1'b0;
      end else if (ref_rise_i) begin
        count <= last_w ? 14'h0000 : count + 14'h0001; // RULE_19
        if (ratio_i > 14'h0001 && flip_w) begin
          div_level_o <= last_w ? 1'b0 : 1'b1; // RULE_01
        end
      end
    end
  end
endmodule : ref_counter
`default_nettype wire

/* verilog/ref_path_control.sv */
// Reference path selection, reference divider control and general purpose output bus
// Function
// RULE_01 - 14-bit ratio divides by 1 to 16383
// RULE_02 - Square-wave input selected after reset
// RULE_03 - Software enables sine buffer and mux itself
// RULE_04 - Auto bit 15 overrides manual bits
// RULE_05 - Auto, ratio two or more: divided output
// RULE_06 - Auto, ratio one: undivided reference passes
// RULE_07 - Manual: divider runs only with enable bit
// RULE_08 - Manual: bit 14 picks divided or undivided
// RULE_09 - Software should keep auto selection set
// RULE_10 - Modulator clock from square input when chosen
// RULE_11 - VCO even ratio limits per mode
// RULE_12 - Fractional ratio swings four about average
// RULE_13 - Software keeps detector frequency within limits
// RULE_14 - Three-pin output bus, function by select
// RULE_15 - Select codes 0-4,6,7,9,10 accepted
// RULE_16 - Code zero drives register data bits
// RULE_17 - Select in bits 3:0; code ten modulator
// RULE_18 - Party holds reset low over reference period
// RULE_19 - One output cycle per N input cycles
// RULE_20 - Source switching makes no short pulses
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ref_path_control (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire refdiv_pkg::reg_req_t req_i,
  output logic [15:0] rdata_o,
  input wire logic square_ref_i,
  input wire logic sine_reference_pin_i,
  input wire refdiv_pkg::gpo_sources_t src_i,
  output logic pfd_ref_o,
  output logic dsm_clk_sel_o,
  output logic dsm_clk_en_o,
  output logic vco_ratio_ok_o,
  output logic [2:0] gpo_o,
  output logic [2:0] gpo_oe_o
);
  import refdiv_pkg::*;

  logic [15:0] ref_div_control;
  logic [15:0] ref_path_config;
  logic [15:0] general_output_control;
  logic [15:0] vco_div_control;
  logic ref_q;
  logic sel_divided;
  logic divided_q;
  logic direct_q;
  logic [2:0] next_gpo;
  logic next_ratio_ok;

  // Register writes at the printed offsets
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ref_div_control <= REF_DIV_RESET;
      ref_path_config <= REF_PATH_RESET; // RULE_02
      general_output_control <= GPO_RESET;
      vco_div_control <= VCO_DIV_RESET;
    end else if (ce_i && req_i.wr) begin
      if (req_i.addr == REF_DIV_CONTROL_ADDR) ref_div_control <= req_i.wdata;
      if (req_i.addr == REF_PATH_CONFIG_ADDR) ref_path_config <= req_i.wdata;
      if (req_i.addr == GENERAL_OUTPUT_CONTROL_ADDR) general_output_control <= req_i.wdata;
      if (req_i.addr == VCO_DIV_CONTROL_ADDR) vco_div_control <= req_i.wdata;
    end
  end

  // Field decode
  wire auto_sel_w = ref_div_control[AUTO_SEL_BIT];
  wire [13:0] ratio_w = ref_div_control[RATIO_W-1:0];
  wire ratio_big_w = ratio_w > RATIO_ONE;
  wire sq_en_w = ref_path_config[SQ_BUF_EN_BIT];
  wire sin_en_w = ref_path_config[SIN_BUF_EN_BIT];
  wire sin_sel_w = ref_path_config[SIN_SEL_BIT];
  // Auto mode ignores manual enable and output select
  wire div_run_w = auto_sel_w ? ratio_big_w : ref_path_config[DIV_EN_BIT]; // RULE_04 RULE_05 RULE_07
  wire want_div_w = auto_sel_w ? ratio_big_w : ref_div_control[MAN_OUT_SEL_BIT]; // RULE_06 RULE_08
  // Input mux: a disabled buffer contributes a low level (software picks one, per RULE_03)
  wire ref_in_w = sin_sel_w ? (sine_reference_pin_i & sin_en_w) : (square_ref_i & sq_en_w);
  wire ref_rise_w = ref_in_w & ~ref_q;
  wire div_level_w;

  ref_counter u_counter (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .run_i(div_run_w),
    .ref_rise_i(ref_rise_w),
    .ratio_i(ratio_w),
    .div_level_o(div_level_w)
  );

  // Glitch-free switch: selection changes only while both sources are low,
  // so no pulse shorter than half an input period reaches the detector
  wire switch_ok_w = ~ref_in_w & ~div_level_w & ~direct_q & ~divided_q;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ref_q <= 1'b0;
      sel_divided <= 1'b0;
      direct_q <= 1'b0;
      divided_q <= 1'b0;
      pfd_ref_o <= 1'b0;
    end else if (ce_i) begin
      ref_q <= ref_in_w;
      direct_q <= ref_in_w;
      divided_q <= div_level_w;
      // Bit 14 wins even with the divider stopped: its output then rests low
      if (switch_ok_w) sel_divided <= want_div_w; // RULE_08 RULE_20
      pfd_ref_o <= sel_divided ? div_level_w : ref_in_w;
    end
  end

  // Modulator clock source: square input when enabled and sine select cleared
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      dsm_clk_sel_o <= 1'b0;
      dsm_clk_en_o <= 1'b0;
    end else if (ce_i) begin
      dsm_clk_en_o <= ref_path_config[SQ_TO_DIG_BIT];
      dsm_clk_sel_o <= ~(ref_path_config[SQ_TO_DIG_BIT] & ~ref_path_config[DSM_SIN_SEL_BIT]); // RULE_10
    end
  end

  // VCO path ratio check: even, within per-mode limits; fractional leaves swing margin
  wire [17:0] vco_ratio_w = {2'b00, vco_div_control[DATA_W-1:FRAC_MODE_BIT+1], 1'b0};
  wire frac_w = vco_div_control[FRAC_MODE_BIT];
  wire [17:0] lo_w = frac_w ? VCO_FRAC_MIN : VCO_INT_MIN;
  wire [17:0] hi_w = frac_w ? VCO_FRAC_MAX : VCO_INT_MAX;
  assign next_ratio_ok = (vco_ratio_w >= lo_w) && (vco_ratio_w <= hi_w); // RULE_11 RULE_12

  // Output bus source select
  wire [3:0] gpo_sel_w = general_output_control[GPO_SEL_LSB +: 4]; // RULE_17
  wire [2:0] gpo_data_w = general_output_control[GPO_DATA_LSB +: 3];
  always_comb begin
    case (gpo_sel_w) // RULE_14 RULE_15
      GPO_DATA: next_gpo = gpo_data_w; // RULE_16
      GPO_DIVIDERS: next_gpo = {ref_in_w, div_level_w, src_i.vco_div};
      GPO_LOCK: next_gpo = {src_i.pfd_up, src_i.pfd_dn, src_i.lock_win};
      GPO_SLIP: next_gpo = {src_i.slip_ref, src_i.slip_vco, src_i.pfd_strobe};
      GPO_STROBE: next_gpo = {sine_reference_pin_i, div_level_w, src_i.frac_strobe};
      GPO_ACCUM: next_gpo = src_i.accum_msb;
      GPO_AUX: next_gpo = {src_i.aux_clk, src_i.ring_osc, src_i.dsm_clk};
      GPO_VCO_LE: next_gpo = src_i.vco_le;
      GPO_DSM: next_gpo = src_i.dsm_out; // RULE_17
      default: next_gpo = 3'h0;
    endcase
  end
  wire gpo_valid_w = (gpo_sel_w <= GPO_STROBE) || (gpo_sel_w == GPO_ACCUM) ||
                     (gpo_sel_w == GPO_AUX) || (gpo_sel_w == GPO_VCO_LE) || (gpo_sel_w == GPO_DSM);

  // Registered output pins; undefined codes leave the bus tristated
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      gpo_o <= 3'h0;
      gpo_oe_o <= 3'h0;
      vco_ratio_ok_o <= 1'b0;
    end else if (ce_i) begin
      gpo_o <= next_gpo;
      gpo_oe_o <= {3{gpo_valid_w}};
      vco_ratio_ok_o <= next_ratio_ok;
    end
  end

  // Read port, data the cycle after the strobe, zero otherwise
  wire [15:0] status_w = {11'h000, next_ratio_ok, sel_divided, div_run_w, div_level_w, ref_in_w};
  wire [15:0] rd_mux_w =
    (req_i.addr == REF_DIV_CONTROL_ADDR) ? ref_div_control :
    (req_i.addr == REF_PATH_CONFIG_ADDR) ? ref_path_config :
    (req_i.addr == GENERAL_OUTPUT_CONTROL_ADDR) ? general_output_control :
    (req_i.addr == VCO_DIV_CONTROL_ADDR) ? vco_div_control :
    (req_i.addr == PATH_STATUS_ADDR) ? status_w : 16'h0000;
  always_ff @(posedge clock_i) begin
    if (rst_i) rdata_o <= 16'h0000;
    else if (ce_i) rdata_o <= req_i.rd ? rd_mux_w : 16'h0000;
  end

  // Checks
  auto_run_a: assert property (@(posedge clock_i) disable iff (rst_i)
    auto_sel_w |-> (div_run_w == ratio_big_w)) else $error("auto run wrong"); // RULE_05
  auto_one_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (auto_sel_w && ratio_w == RATIO_ONE) |-> !div_run_w) else $error("ratio one runs"); // RULE_06
  manual_en_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !auto_sel_w |-> (div_run_w == ref_path_config[DIV_EN_BIT])) else $error("manual en"); // RULE_07
  gpo_data_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && gpo_sel_w == GPO_DATA) |=> (gpo_o == $past(gpo_data_w))) else $error("gpo data"); // RULE_16
  gpo_dsm_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && gpo_sel_w == GPO_DSM) |=> (gpo_o == $past(src_i.dsm_out))) else $error("gpo dsm"); // RULE_17
  dsm_clock_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && ref_path_config[SQ_TO_DIG_BIT] && !ref_path_config[DSM_SIN_SEL_BIT])
    |=> !dsm_clk_sel_o) else $error("dsm clock"); // RULE_10
  sel_switch_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (sel_divided != $past(sel_divided)) |-> !$past(direct_q)) else $error("glitch switch"); // RULE_20
  reset_sq_a: assert property (@(posedge clock_i)
    $past(rst_i) |-> (ref_path_config[SQ_BUF_EN_BIT] && !sin_sel_w)) else $error("reset src"); // RULE_02
endmodule : ref_path_control
`default_nettype wire

/* verification/ref_source_model.sv */
// Reference clock source model: square and sine references
`timescale 1ns/1ps
`default_nettype none
module ref_source_model #(
  parameter int SQ_HALF = 2,
  parameter int SIN_HALF = 3
) (
  input wire logic clock_i,
  input wire logic sq_run_i,
  input wire logic sin_run_i,
  output logic square_o,
  output logic sine_o
);
  int sq_cnt = 0;
  int sin_cnt = 0;
  initial begin
    square_o = 1'b0;
    sine_o = 1'b0;
  end
  // A stopped source rests low, as an open input would, so stale edges never leak
  always @(posedge clock_i) begin
    sq_cnt <= (sq_cnt + 1) % SQ_HALF;
    sin_cnt <= (sin_cnt + 1) % SIN_HALF;
    if (!sq_run_i) square_o <= 1'b0;
    else if (sq_cnt == SQ_HALF - 1) square_o <= ~square_o;
    if (!sin_run_i) sine_o <= 1'b0;
    else if (sin_cnt == SIN_HALF - 1) sine_o <= ~sine_o;
  end
endmodule : ref_source_model
`default_nettype wire

/* verification/reference_divider_gpo_select_tb_top.sv */
// Self-checking testbench for the reference path control block
`timescale 1ns/1ps
`default_nettype none
module reference_divider_gpo_select_tb_top;
  import refdiv_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  reg_req_t req = '0;
  gpo_sources_t src = '0;
  logic [15:0] rdata;
  logic sq_run = 1'b1;
  logic sin_run = 1'b0;
  logic square_ref, sine_ref, pfd_ref, dsm_sel, dsm_en, ratio_ok;
  logic [2:0] gpo, gpo_oe;
  int mismatches = 0;
  int total_checks = 0;
  int pfd_rises = 0;
  logic pfd_prev = 1'b0;
  logic [15:0] d;

  always #10 clock_i = ~clock_i;

  ref_path_control u_dut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req),
    .rdata_o(rdata), .square_ref_i(square_ref), .sine_reference_pin_i(sine_ref),
    .src_i(src), .pfd_ref_o(pfd_ref), .dsm_clk_sel_o(dsm_sel), .dsm_clk_en_o(dsm_en),
    .vco_ratio_ok_o(ratio_ok), .gpo_o(gpo), .gpo_oe_o(gpo_oe));
  ref_source_model u_src (.clock_i(clock_i), .sq_run_i(sq_run), .sin_run_i(sin_run),
    .square_o(square_ref), .sine_o(sine_ref));

  // Edges counted on the falling clock, well clear of the registered output update
  always @(negedge clock_i) begin
    if (pfd_ref === 1'b1 && pfd_prev === 1'b0) pfd_rises++;
    pfd_prev = pfd_ref;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clock_i);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge clock_i);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clock_i);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // Window is a whole number of output periods, so the count is exact
  task automatic rises(input int span, input int exp);
    int start;
    repeat (80) @(posedge clock_i);
    start = pfd_rises;
    repeat (span) @(posedge clock_i);
    check(16'(pfd_rises - start), 16'(exp));
  endtask : rises
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic test_regs();
    rd(REF_DIV_CONTROL_ADDR);
    check(d, REF_DIV_RESET);
    rd(REF_PATH_CONFIG_ADDR);
    check(d, REF_PATH_RESET);
    rd(8'h7F);
    check(d, 16'h0000);
    @(posedge clock_i);
    ce_i <= 1'b0;
    wr(GENERAL_OUTPUT_CONTROL_ADDR, 16'h0070);
    ce_i <= 1'b1;
    rd(GENERAL_OUTPUT_CONTROL_ADDR);
    check(d, 16'h0000);
    rises(40, 10);
    wr(REF_DIV_CONTROL_ADDR, 16'hBFFF);
    rd(REF_DIV_CONTROL_ADDR);
    check(d, 16'hBFFF);
    $display("register test done");
  endtask : test_regs
  task automatic test_auto();
    int r [3] = '{2, 3, 5};
    wr(REF_PATH_CONFIG_ADDR, 16'h0001);
    foreach (r[i]) begin
      wr(REF_DIV_CONTROL_ADDR, 16'h8000 | 16'(r[i]));
      rises(r[i] * 16, 4);
    end
    wr(REF_DIV_CONTROL_ADDR, 16'h8001);
    rises(40, 10);
    $display("auto select test done");
  endtask : test_auto
  task automatic test_manual();
    wr(REF_PATH_CONFIG_ADDR, 16'h0005);
    wr(REF_DIV_CONTROL_ADDR, 16'h4003);
    rises(48, 4);
    wr(REF_DIV_CONTROL_ADDR, 16'h0003);
    rises(40, 10);
    wr(REF_PATH_CONFIG_ADDR, 16'h0001);
    wr(REF_DIV_CONTROL_ADDR, 16'h4003);
    rises(48, 0);
    $display("manual select test done");
  endtask : test_manual
  task automatic test_sine();
    wr(REF_DIV_CONTROL_ADDR, 16'h8001);
    wr(REF_PATH_CONFIG_ADDR, 16'h000A);
    sin_run <= 1'b1;
    rises(60, 10);
    wr(REF_PATH_CONFIG_ADDR, 16'h0015);
    repeat (3) @(posedge clock_i);
    check({14'h0, dsm_en, dsm_sel}, 16'h0002);
    wr(REF_PATH_CONFIG_ADDR, 16'h0035);
    repeat (3) @(posedge clock_i);
    check({14'h0, dsm_en, dsm_sel}, 16'h0003);
    $display("source select test done");
  endtask : test_sine
  task automatic test_vco();
    logic [15:0] v [5] = '{16'h0040, 16'h003E, 16'h0049, 16'h0047, 16'h0041};
    logic ok [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    foreach (v[i]) begin
      wr(VCO_DIV_CONTROL_ADDR, v[i]);
      repeat (3) @(posedge clock_i);
      check({15'h0, ratio_ok}, {15'h0, ok[i]});
    end
    // Status word: ratio flag set, divider idle and bypassed under auto ratio one
    wr(VCO_DIV_CONTROL_ADDR, 16'h0040);
    rd(PATH_STATUS_ADDR);
    check(d & 16'hFFFE, 16'h0010);
    $display("path divider limit test done");
  endtask : test_vco
  task automatic test_gpo();
    logic [3:0] c [10] = '{4'h0, 4'h2, 4'h3, 4'h6, 4'h7, 4'hA, 4'h1, 4'h4, 4'h9, 4'h5};
    logic [5:0] e [10] = '{6'h3D, 6'h3B, 6'h3C, 6'h3E, 6'h3B, 6'h39, 6'h38, 6'h38, 6'h38, 6'h00};
    foreach (c[i]) begin
      wr(GENERAL_OUTPUT_CONTROL_ADDR, 16'h0050 | 16'(c[i]));
      repeat (3) @(posedge clock_i);
      #1;
      if (i < 6 || i >= 8) check({10'h0, gpo_oe, gpo}, {10'h0, e[i]});
      else check({13'h0, gpo_oe}, 16'h0007);
    end
    $display("output bus test done");
  endtask : test_gpo

  initial begin
    {src.lock_win, src.pfd_dn, src.slip_ref, src.ring_osc, src.dsm_clk} = 5'h1F;
    src.accum_msb = 3'b110;
    src.dsm_out = 3'b001;
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    test_regs();
    test_auto();
    test_manual();
    test_sine();
    test_vco();
    test_gpo();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    mismatches++;
    $display("[FAIL] %0t ns watchdog expired", $time);
    complete_run();
  end
endmodule : reference_divider_gpo_select_tb_top
`default_nettype wire
